// file: sarp_regs.svh
// constants of the serial conversion port: widths and timing counts
// assumes a 200 MHz system clock on mclk_in
//
// Behaviour
// (RL1) convert rising edge starts conversion, picks mode
// (RL2) sdi low at edge selects daisy chain
// (RL3) sdi high at edge selects chip select
// (RL4) chip select: output driven only when convert low; the code also drives it when sdi is low
// (RL5) daisy chain: data read while convert high
// (RL6) daisy chain: sdi reaches sdo after 20 clocks
// (RL7) chip select: sdi or convert low enables output
// (RL8) busy indicator if sdi/convert low at completion
// (RL9) programming: 16-bit word, sampled on sck rise
// (RL10) result shifted out one bit per sck
// (RL11) top bit shown once convert falls; the code puts it on sdo at the sck fall after the load rise
// (RL12) next bit after each sck falling edge
// (RL13) output released after convert rises
// (RL14) mode held until next convert rising edge
`ifndef SARP_REGS_SVH
`define SARP_REGS_SVH
`define SARP_RES_W 20
`define SARP_PROG_W 16
`define SARP_CHAIN_DLY 20
`define SARP_CLK_NS 5
`define SARP_CONV_NS 300
`define SARP_CONV_CYC ((`SARP_CONV_NS + `SARP_CLK_NS - 1) / `SARP_CLK_NS)
`endif

// file: sarp_pkg.sv
// types of the serial conversion port
// assumes sarp_regs.svh is on the include path
`default_nettype none
package sarp_pkg;
    typedef enum logic {SARP_CHAIN, SARP_CS} sarp_mode_t;
    typedef enum logic [1:0] {SARP_IDLE, SARP_CONV, SARP_DONE} sarp_st_t;
    // pins as seen by the host
    typedef struct packed {
        logic convert_start;
        logic sdi;
    } sarp_pins_t;
    // serial output pin, two signals
    typedef struct packed {
        logic sdo;
        logic sdo_oe_n;
    } sarp_out_t;
endpackage : sarp_pkg
`default_nettype wire

// file: sarp_port.sv
// device side of the serial conversion port
// convert/sdi are sampled into mclk domain; sck is the link clock and
// clocks the shift logic; the result word crosses as held quasi-static data
`include "sarp_regs.svh"
`default_nettype none
module sarp_port #(
    parameter int RES_W = `SARP_RES_W,
    parameter int PROG_W = `SARP_PROG_W
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic sck_in,
    input wire sarp_pkg::sarp_pins_t pins_in,
    input wire logic [RES_W-1:0] sample_in,
    output logic sdo_out,
    output logic sdo_oe_n_out,
    output logic busy_out,
    output logic [PROG_W-1:0] prog_word_out,
    output logic prog_valid_out
);
    import sarp_pkg::*;

    // elaboration check: chain delay equals result width; the word
    // shifter needs two bits at least and the 5-bit counter caps it
    if (RES_W != `SARP_CHAIN_DLY || PROG_W < 2 || PROG_W > 32)
    begin : g_bad
        $error("sarp_port: unsupported width");
    end

    localparam int CONV_CYC = `SARP_CONV_CYC;

    // two-stage synchronisers for pins in mclk domain
    logic [1:0] cnv_s1_r, cnv_s1_nxt; // bit0 first stage, bit1 second
    logic [1:0] sdi_s1_r, sdi_s1_nxt;
    logic cnv_d_r, cnv_d_nxt; // delayed synced convert for edge
    sarp_mode_t mode_r, mode_nxt;
    sarp_st_t st_r, st_nxt;
    logic [8:0] cnt_r, cnt_nxt;
    logic [RES_W-1:0] res_r, res_nxt; // held result, crosses to sck
    logic busy_r, busy_nxt;
    logic cs_sel_r, cs_sel_nxt; // output enable decision, mclk side
    logic oe_n_r, oe_n_nxt;
    logic cnv_rise;

    // synchroniser and convert-edge bookkeeping
    always_comb begin
        cnv_s1_nxt = {cnv_s1_r[0], pins_in.convert_start};
        sdi_s1_nxt = {sdi_s1_r[0], pins_in.sdi};
        cnv_d_nxt = cnv_s1_r[1];
    end
    assign cnv_rise = cnv_s1_r[1] && !cnv_d_r; // RL1

    // conversion sequencer and mode choice
    always_comb begin
        st_nxt = st_r;
        mode_nxt = mode_r;
        cnt_nxt = cnt_r;
        res_nxt = res_r;
        busy_nxt = busy_r;
        if (cnv_rise) begin
            // mode latched once per edge, kept until the next // RL14
            mode_nxt = sdi_s1_r[1] ? SARP_CS : SARP_CHAIN; // RL2 RL3
            st_nxt = SARP_CONV; // RL1
            cnt_nxt = 9'(CONV_CYC);
            busy_nxt = 1'b0;
        end else begin
            case (st_r)
                SARP_CONV: begin
                    if (cnt_r == 9'h001) begin
                        st_nxt = SARP_DONE;
                        res_nxt = sample_in;
                        // busy only flagged when a select is low // RL8
                        busy_nxt = (mode_r == SARP_CS) &&
                            (!sdi_s1_r[1] || !cnv_s1_r[1]);
                    end else begin
                        cnt_nxt = cnt_r - 9'h001;
                    end
                end
                default: ;
            endcase
        end
    end

    // output enable: cs mode when convert or sdi low, chain while high
    always_comb begin
        if (mode_r == SARP_CS) begin
            cs_sel_nxt = !cnv_s1_r[1] || !sdi_s1_r[1]; // RL4 RL7
        end else begin
            cs_sel_nxt = cnv_s1_r[1] && !cnv_rise; // RL5
        end
        oe_n_nxt = !(cs_sel_r && st_r == SARP_DONE) || cnv_rise; // RL13
    end

    // mclk registers only
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            cnv_s1_r <= 2'h0;
            sdi_s1_r <= 2'h3;
            cnv_d_r <= 1'b0;
            mode_r <= SARP_CS;
            st_r <= SARP_IDLE;
            cnt_r <= 9'h000;
            res_r <= '0;
            busy_r <= 1'b0;
            cs_sel_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            cnv_s1_r <= cnv_s1_nxt;
            sdi_s1_r <= sdi_s1_nxt;
            cnv_d_r <= cnv_d_nxt;
            mode_r <= mode_nxt;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            res_r <= res_nxt;
            busy_r <= busy_nxt;
            cs_sel_r <= cs_sel_nxt;
            oe_n_r <= oe_n_nxt;
        end
    end
    assign sdo_oe_n_out = oe_n_r;
    assign busy_out = busy_r;

    // ---------------- mclk-side checks ----------------
    // a conversion: the synced edge, then the sequencer in its count
    sequence s_conv_begin;
        cnv_rise ##1 (st_r == SARP_CONV);
    endsequence
    // cs mode with both selects high for three cycles running; the
    // enable decision is two registers deep, hence the three
    sequence s_cs_quiet;
        (mode_r == SARP_CS && cnv_s1_r[1] && sdi_s1_r[1])[*3];
    endsequence

    // every synced convert edge starts the sequencer
    a_conv_start: assert property (@(posedge mclk_in) // RL1
        disable iff (reset_in) cnv_rise |=> st_r == SARP_CONV)
        else $error("conversion did not start on convert edge");

    // mode follows the synced sdi level at the edge
    a_mode_pick: assert property (@(posedge mclk_in) // RL2 RL3
        disable iff (reset_in)
        cnv_rise |=> mode_r == ($past(sdi_s1_r[1]) ? SARP_CS : SARP_CHAIN))
        else $error("interface mode not taken from sdi");

    // no edge, no change of mode
    a_mode_hold: assert property (@(posedge mclk_in) // RL14
        disable iff (reset_in) !cnv_rise |=> $stable(mode_r))
        else $error("interface mode changed without convert edge");

    // the result is ready a fixed count after the start
    a_conv_len: assert property (@(posedge mclk_in) // RL1
        disable iff (reset_in) s_conv_begin |-> ##60 st_r == SARP_DONE)
        else $error("conversion length wrong");

    // the output lets go on the cycle after the edge
    a_oe_release: assert property (@(posedge mclk_in) // RL13
        disable iff (reset_in) cnv_rise |=> sdo_oe_n_out)
        else $error("serial output not released after convert edge");

    // cs mode, nothing selected: output stays off
    a_cs_quiet: assert property (@(posedge mclk_in) // RL4 RL7
        disable iff (reset_in) s_cs_quiet |-> sdo_oe_n_out)
        else $error("serial output driven while deselected");

    // busy only rises at completion with a select low
    a_busy_when: assert property (@(posedge mclk_in) // RL8
        disable iff (reset_in) $rose(busy_out) |->
        ($past(st_r) == SARP_CONV &&
        $past(!sdi_s1_r[1] || !cnv_s1_r[1])))
        else $error("busy raised outside completion");

    // a new conversion clears the busy indicator
    a_busy_clear: assert property (@(posedge mclk_in) // RL8
        disable iff (reset_in) cnv_rise |=> !busy_out)
        else $error("busy not cleared by convert edge");

    // ---------------- sck domain ----------------
    // no reset reaches sck; it only runs in frames. res_r and mode_r
    // are mclk registers read here as quasi-static words: both settle
    // during the conversion, long before the first sck rise of a frame,
    // so no bit of them moves near an sck edge.
    // cs mode: the shifter loads on every rise with convert high.
    // chain mode: it loads only on the first rise with convert high,
    // and shifts sdi in on the later ones, so upstream data follows.
    // limitation: the host must give one sck rise with convert high
    // before reading, or the top bit is not on sdo yet.
    logic [RES_W-1:0] sh_r, sh_nxt;
    logic cnv_seen_r, cnv_seen_nxt; // convert level at previous sck rise
    logic [PROG_W-1:0] pw_r, pw_nxt;
    logic [4:0] pcnt_r, pcnt_nxt;
    logic pv_r, pv_nxt;
    logic sdo_r, sdo_nxt;

    // rising edge: sample sdi for programming and the chain
    always_comb begin
        pw_nxt = {pw_r[PROG_W-2:0], pins_in.sdi}; // RL9
        pcnt_nxt = pins_in.convert_start ? 5'h00 : pcnt_r + 5'h01;
        pv_nxt = !pins_in.convert_start &&
            pcnt_r == 5'(PROG_W - 1); // RL9
        cnv_seen_nxt = pins_in.convert_start;
        if (pins_in.convert_start &&
            (mode_r == SARP_CS || !cnv_seen_r)) begin
            // load the held result at the head of a frame
            sh_nxt = res_r; // RL10
        end else begin
            // chain: sdi enters at the bottom, appears after RES_W
            sh_nxt = {sh_r[RES_W-2:0], pins_in.sdi}; // RL6 RL10
        end
    end
    // sck registers only
    always_ff @(posedge sck_in) begin
        pw_r <= pw_nxt;
        pcnt_r <= pcnt_nxt;
        pv_r <= pv_nxt;
        cnv_seen_r <= cnv_seen_nxt;
        sh_r <= sh_nxt;
    end
    assign prog_word_out = pw_r;
    assign prog_valid_out = pv_r;

    // falling edge moves the next bit onto sdo // RL12
    always_comb begin
        sdo_nxt = sh_r[RES_W-1]; // RL11
    end
    always_ff @(negedge sck_in) begin
        sdo_r <= sdo_nxt; // RL12
    end
    assign sdo_out = sdo_r;
endmodule : sarp_port
`default_nettype wire

// file: sarp_host.sv
// host model: drives convert, sdi and a framed 64 ns link clock
// assumes sarp_pkg is compiled first; sck stands still between frames
`default_nettype none
module sarp_host (
    input wire logic sdo_in,
    output logic sck_out,
    output var sarp_pkg::sarp_pins_t pins_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle: convert low, sdi high
    initial begin
        sck_out = 1'b0;
        pins_out = 2'h1;
    end
    // one link clock period, rise then fall
    task automatic tick();
        #32 sck_out = 1'b1;
        #32 sck_out = 1'b0;
    endtask : tick
    // convert pulse; sdi level at the edge picks the mode
    task automatic convert(input logic mode_sdi);
        pins_out.convert_start = 1'b0;
        pins_out.sdi = mode_sdi;
        #20 pins_out.convert_start = 1'b1;
        #400 tick();
    endtask : convert
    // cs conversion with sdi dropped before completion
    task automatic busy_conv();
        pins_out.convert_start = 1'b0;
        pins_out.sdi = 1'b1;
        #20 pins_out.convert_start = 1'b1;
        #40 pins_out.sdi = 1'b0;
        #400;
    endtask : busy_conv
    // chain read, convert high: own word, then upstream word
    task automatic chain(input logic [19:0] up, output logic [39:0] w);
        for (int i = 0; i < 40; i++) begin
            pins_out.sdi = (i < 20) ? up[19 - i] : 1'b0;
            #2 w = {w[38:0], sdo_in};
            tick();
        end
    endtask : chain
    // read msb first; sampled 2 ns after the fall, once settled
    task automatic read(output logic [19:0] w);
        pins_out.convert_start = 1'b0;
        #20;
        for (int i = 0; i < 20; i++) begin
            #2 w = {w[18:0], sdo_in};
            tick();
        end
    endtask : read
    // programming word, msb first, convert held low
    task automatic prog(input logic [15:0] wd);
        pins_out.convert_start = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            pins_out.sdi = wd[i];
            tick();
        end
        pins_out.sdi = 1'b1;
    endtask : prog
endmodule : sarp_host
`default_nettype wire

// file: sarp_port_tb.sv
// self-checking bench of the serial conversion port
// assumes sarp_pkg, sarp_port and sarp_host are compiled first
`default_nettype none
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin \
    miscompares++; $display("CHECK FAILED %s exp %h got %h", nm, e, a); \
    end end
module sarp_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sarp_pkg::*;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic sck, sdo, oe_n, busy, pv;
    logic [19:0] sample_in = 20'h0_0000;
    logic [19:0] got;
    logic [39:0] got2;
    logic [15:0] pw;
    sarp_pins_t pins;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    // rows: sample in beside the word expected on the wire
    logic [19:0] row_in [3] = '{20'ha_5a5a, 20'h8_0001, 20'hf_ffff};
    logic [19:0] row_exp [3] = '{20'ha_5a5a, 20'h8_0001, 20'hf_ffff};
    always #2.5 mclk_in = ~mclk_in;
    // hang guard; the tests need about 2100 cycles
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            print_verdict();
        end
    end
    sarp_port u_sarp_port (.mclk_in(mclk_in), .reset_in(reset_in),
        .sck_in(sck), .pins_in(pins), .sample_in(sample_in),
        .sdo_out(sdo), .sdo_oe_n_out(oe_n), .busy_out(busy),
        .prog_word_out(pw), .prog_valid_out(pv));
    sarp_host u_sarp_host (.sdo_in(sdo), .sck_out(sck), .pins_out(pins));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (2) @(posedge mclk_in);
        #1 reset_in = 1'b0;
        `CHK("oe_n reset", 1'b1, oe_n)
        `CHK("busy reset", 1'b0, busy)
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk_in);
            #1 sample_in = row_in[i];
            u_sarp_host.convert(1'b1);
            `CHK("busy", 1'b0, busy)
            u_sarp_host.read(got);
            `CHK("oe_n read", 1'b0, oe_n)
            `CHK("word", row_exp[i], got)
            $display("row %0d done", i);
        end
        // chain: own word first, upstream word 20 clocks later
        @(posedge mclk_in);
        #1 sample_in = 20'h3_c3c3;
        u_sarp_host.convert(1'b0);
        u_sarp_host.chain(20'h5_0f0a, got2);
        `CHK("oe_n chain", 1'b0, oe_n)
        `CHK("chain word", {20'h3_c3c3, 20'h5_0f0a}, got2)
        $display("chain done");
        // back-to-back conversion: output must let go
        u_sarp_host.convert(1'b1);
        `CHK("oe_n release", 1'b1, oe_n)
        $display("release done");
        // sdi dropped during conversion: busy and output enabled
        u_sarp_host.busy_conv();
        `CHK("busy set", 1'b1, busy)
        `CHK("oe_n sdi low", 1'b0, oe_n)
        $display("busy done");
        u_sarp_host.prog(16'hc3a5);
        `CHK("prog word", 16'hc3a5, pw)
        `CHK("prog valid", 1'b1, pv)
        $display("prog done");
        print_verdict();
    end
endmodule : sarp_port_tb
`default_nettype wire
